// [lai_pkg.sv]
// shared constants and types for the lookup table address interpolator
package lai_pkg;
   localparam int unsigned SAMPLE_W     = 12;
   localparam int unsigned WORD_W       = 16;
   localparam int unsigned ADDR_W       = 8;
   localparam int unsigned FRAC_W       = 3;
   localparam int unsigned SHIFT_BASE   = 7;
   localparam int unsigned START_SHIFT  = 5;
   localparam int unsigned LEN_UNIT     = 32;
   localparam int unsigned THR_W        = 12;
   localparam logic [11:0] THR_RESET    = 12'h7FF;
   // command byte layout
   localparam int unsigned CMD_RW_BIT   = 7;
   localparam logic [6:0]  CMD_UPPER_CH1 = 7'h20;
   localparam logic [6:0]  CMD_UPPER_CH2 = 7'h28;
   // lookup table configuration word fields
   localparam int unsigned CFG_OFF_LSB  = 10;
   localparam int unsigned CFG_INT_LSB  = 8;
   localparam int unsigned CFG_PSZ_LSB  = 6;
   localparam int unsigned CFG_LEN_LSB  = 3;
   localparam int unsigned CFG_SOT_LSB  = 0;

   typedef enum logic [1:0] {
      LAI_IDLE  = 2'b00,
      LAI_FETCH1 = 2'b01,
      LAI_FETCH2 = 2'b11,
      LAI_DONE  = 2'b10
   } lai_state_t;
endpackage : lai_pkg

// [lai_ptr_calc.sv]
// combinational pointer arithmetic: shift, offset, clamp, base address
`timescale 1ns/1ps
`default_nettype none
module lai_ptr_calc (
   input  wire logic [11:0] sample_i,
   input  wire logic [15:0] cfg_i,
   output logic      [7:0]  addr_o,
   output logic      [2:0]  frac_o,
   output logic      [1:0]  int_deg_o,
   output logic             cfg_bad_o
);
   logic signed [5:0]  off;
   logic [1:0]         psz;
   logic [1:0]         ideg;
   logic [2:0]         len_sel;
   logic [2:0]         table_start_select;
   logic [11:0]        shifted;
   logic signed [15:0] ptr;
   logic signed [15:0] off_sc;
   logic signed [15:0] sum;
   logic [15:0]        last_fx;
   logic [10:0]        bounded;
   logic [7:0]         length;

   always_comb begin
      off     = cfg_i[lai_pkg::CFG_OFF_LSB +: 6];
      ideg    = cfg_i[lai_pkg::CFG_INT_LSB +: 2];
      psz     = cfg_i[lai_pkg::CFG_PSZ_LSB +: 2];
      len_sel = cfg_i[lai_pkg::CFG_LEN_LSB +: 3];
      table_start_select     = cfg_i[lai_pkg::CFG_SOT_LSB +: 3];
      // shift count 7 - size - degree never goes below 1
      shifted = sample_i >> (3'(lai_pkg::SHIFT_BASE) - 3'(psz)
                - 3'(ideg));
      ptr     = signed'({4'h0, shifted});
      case (psz)
         2'b10:   off_sc = 16'(signed'(off)) <<< 1;
         2'b11:   off_sc = 16'(signed'(off)) <<< 2;
         default: off_sc = 16'(signed'(off));
      endcase
      // offset lines up with the integer part
      sum = ptr + (off_sc <<< ideg);
      length = 8'(len_sel) * 8'(lai_pkg::LEN_UNIT);
      cfg_bad_o = (len_sel == 3'h0) || (len_sel == 3'h7) ||
                  (table_start_select < 3'h2);
      // last index in fixed point, fraction zero
      last_fx = (16'(length) - 16'h0001) << ideg;
      if (sum < 16'sh0000)
         bounded = 11'h000;
      else if (unsigned'(sum) > last_fx)
         bounded = 11'(last_fx);
      else
         bounded = 11'(sum);
      addr_o    = 8'((11'(table_start_select) << lai_pkg::START_SHIFT)
                  + (bounded >> ideg));
      frac_o    = 3'((bounded << (2'd3 - ideg)) & 11'h007);
      int_deg_o = ideg;
   end
endmodule // lai_ptr_calc
`default_nettype wire

// [lai_interp.sv]
// linear interpolation between two neighbouring table words
`timescale 1ns/1ps
`default_nettype none
module lai_interp (
   input  wire logic [15:0] first_i,
   input  wire logic [15:0] second_i,
   input  wire logic [2:0]  frac_i,
   output logic      [15:0] value_o
);
   logic signed [17:0] diff;
   logic signed [21:0] prod;
   always_comb begin
      diff    = signed'({2'b00, second_i}) - signed'({2'b00, first_i});
      prod    = 22'(diff) * signed'({19'h0, frac_i});
      // fraction is in eighths; arithmetic shift keeps sign of slope
      value_o = 16'(signed'({6'h00, first_i}) + (prod >>> 3));
   end
endmodule // lai_interp
`default_nettype wire

// [lai_top.sv]
// lookup table address interpolator with upper temperature thresholds
// Functional notes
// - start select maps to base 0x40..0xE0
// - sample shifted right by 7-size-degree
// - low degree bits are the fraction
// - offset scaled by pointer size code
// - signed offset added at integer part
// - pointer checked against table bounds
// - out of bounds pointer clamped
// - table length is length select times 32
// - address is start<<5 plus pointer
// - nonzero fraction fetches two neighbours
// - result is first plus fraction times delta
// - registers are 16 bits via command
// - command top bit selects read/write
// - one upper threshold per channel
// - threshold is 12-bit signed, 3 fractional
// - threshold resets to maximum positive code
// - threshold loadable from nonvolatile store
`timescale 1ns/1ps
`default_nettype none
module lai_top (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   // conversion request
   input  wire logic        conv_valid_i,
   input  wire logic [11:0] sample_i,
   input  wire logic [15:0] lut_cfg_i,
   output logic             conv_ready_o,
   output logic             result_valid_o,
   output logic [15:0]      result_o,
   output logic             cfg_error_o,
   // nonvolatile store read port, data one cycle after address
   output logic [7:0]       mem_addr_o,
   output logic             mem_rd_o,
   input  wire logic [15:0] mem_data_i,
   // serial register port
   input  wire logic        cmd_valid_i,
   input  wire logic [7:0]  cmd_i,
   input  wire logic [15:0] cmd_wdata_i,
   output logic             cmd_rvalid_o,
   output logic [15:0]      cmd_rdata_o,
   // threshold load from nonvolatile store
   input  wire logic        nv_load_i,
   input  wire logic        nv_sel_i,
   input  wire logic [15:0] nv_data_i,
   output logic [11:0]      upper_temp_limit_ch1_o,
   output logic [11:0]      upper_temp_limit_ch2_o
);
   typedef struct packed {
      lai_pkg::lai_state_t state;
      logic [7:0]          addr;
      logic [2:0]          frac;
      logic [15:0]         first;
      logic [15:0]         result;
      logic                rvalid;
      logic                cfg_err;
      logic [15:0]         rdata;
      logic                cmd_rvalid;
      logic [11:0]         upper_temp_limit_ch1;
      logic [11:0]         upper_temp_limit_ch2;
   } lai_regs_t;

   lai_regs_t   cur;
   lai_regs_t   next_cur;
   logic [7:0]  calc_addr;
   logic [2:0]  calc_frac;
   logic        calc_bad;
   logic [15:0] interp_val;
   logic        want_second;
   logic        rd_cmd;
   logic        wr_cmd;
   logic        hit_ch1;
   logic        hit_ch2;

   // command decode is shared by the read and the write paths
   function automatic logic names_reg(input logic [7:0] cmd,
                                      input logic [6:0] code);
      names_reg = (cmd[6:0] == code);
   endfunction

   function automatic logic is_read(input logic [7:0] cmd);
      is_read = cmd[lai_pkg::CMD_RW_BIT];
   endfunction

   function automatic logic [15:0] thr_word(input logic [11:0] t);
      // sign extended so reads look like conversion results
      thr_word = {{4{t[11]}}, t};
   endfunction

   lai_ptr_calc u_calc (
      .sample_i  (sample_i),
      .cfg_i     (lut_cfg_i),
      .addr_o    (calc_addr),
      .frac_o    (calc_frac),
      .int_deg_o (),
      .cfg_bad_o (calc_bad)
   );

   lai_interp u_interp (
      .first_i  (cur.first),
      .second_i (mem_data_i),
      .frac_i   (cur.frac),
      .value_o  (interp_val)
   );

   assign want_second = (cur.frac != 3'h0);
   assign rd_cmd      = cmd_valid_i && is_read(cmd_i);
   assign wr_cmd      = cmd_valid_i && !is_read(cmd_i);
   assign hit_ch1     = names_reg(cmd_i, lai_pkg::CMD_UPPER_CH1);
   assign hit_ch2     = names_reg(cmd_i, lai_pkg::CMD_UPPER_CH2);

   always_comb begin
      next_cur            = cur;
      next_cur.rvalid     = 1'b0;
      next_cur.cmd_rvalid = 1'b0;
      unique case (cur.state)
         lai_pkg::LAI_IDLE: begin
            if (conv_valid_i) begin
               next_cur.addr    = calc_addr;
               next_cur.frac    = calc_frac;
               next_cur.cfg_err = calc_bad;
               next_cur.state   = lai_pkg::LAI_FETCH1;
            end
         end
         lai_pkg::LAI_FETCH1: begin
            next_cur.first = mem_data_i;
            if (want_second) begin
               next_cur.state = lai_pkg::LAI_FETCH2;
            end else begin
               next_cur.result = mem_data_i;
               next_cur.rvalid = 1'b1;
               next_cur.state  = lai_pkg::LAI_DONE;
            end
         end
         lai_pkg::LAI_FETCH2: begin
            next_cur.result = interp_val;
            next_cur.rvalid = 1'b1;
            next_cur.state  = lai_pkg::LAI_DONE;
         end
         lai_pkg::LAI_DONE: begin
            next_cur.state = lai_pkg::LAI_IDLE;
         end
      endcase
      // nonvolatile load comes first; a serial write in the same cycle wins
      if (nv_load_i) begin
         if (nv_sel_i)
            next_cur.upper_temp_limit_ch2 = nv_data_i[11:0];
         else
            next_cur.upper_temp_limit_ch1 = nv_data_i[11:0];
      end
      if (rd_cmd) begin
         next_cur.cmd_rvalid = 1'b1;
         if (hit_ch1) begin
            next_cur.rdata = thr_word(cur.upper_temp_limit_ch1);
         end else if (hit_ch2) begin
            next_cur.rdata = thr_word(cur.upper_temp_limit_ch2);
         end else begin
            // the other registers sit outside this block and read as zero
            next_cur.rdata = 16'h0000;
         end
      end
      if (wr_cmd && hit_ch1) begin
         next_cur.upper_temp_limit_ch1 = cmd_wdata_i[11:0];
      end else if (wr_cmd && hit_ch2) begin
         next_cur.upper_temp_limit_ch2 = cmd_wdata_i[11:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cur                      <= '0;
         cur.state                <= lai_pkg::LAI_IDLE;
         cur.upper_temp_limit_ch1 <= lai_pkg::THR_RESET;
         cur.upper_temp_limit_ch2 <= lai_pkg::THR_RESET;
      end else begin
         cur <= next_cur;
      end
   end

   // the first word is asked for in the take cycle: the store answers one
   // cycle after the address, and the first fetch state consumes that answer
   always_comb begin
      unique case (cur.state)
         lai_pkg::LAI_IDLE: begin
            mem_addr_o = calc_addr;
            mem_rd_o   = conv_valid_i;
         end
         lai_pkg::LAI_FETCH1: begin
            mem_addr_o = want_second ? cur.addr + 8'h01 : cur.addr;
            mem_rd_o   = want_second;
         end
         lai_pkg::LAI_FETCH2,
         lai_pkg::LAI_DONE: begin
            mem_addr_o = cur.addr;
            mem_rd_o   = 1'b0;
         end
      endcase
   end
   assign conv_ready_o          = (cur.state == lai_pkg::LAI_IDLE);
   assign result_valid_o        = cur.rvalid;
   assign result_o              = cur.result;
   assign cfg_error_o           = cur.cfg_err;
   assign cmd_rvalid_o          = cur.cmd_rvalid;
   assign cmd_rdata_o           = cur.rdata;
   assign upper_temp_limit_ch1_o = cur.upper_temp_limit_ch1;
   assign upper_temp_limit_ch2_o = cur.upper_temp_limit_ch2;
endmodule // lai_top
`default_nettype wire

// [lai_checker.sv]
// port-level assertions for the interpolator top
`timescale 1ns/1ps
`default_nettype none
module lai_checker (
   input wire logic        clk_i,
   input wire logic        sys_rst_i,
   input wire logic        conv_valid_i,
   input wire logic        conv_ready_o,
   input wire logic        result_valid_o,
   input wire logic        mem_rd_o,
   input wire logic        cmd_valid_i,
   input wire logic [7:0]  cmd_i,
   input wire logic [15:0] cmd_wdata_i,
   input wire logic        cmd_rvalid_o,
   input wire logic [15:0] cmd_rdata_o,
   input wire logic        nv_load_i,
   input wire logic        nv_sel_i,
   input wire logic [15:0] nv_data_i,
   input wire logic [11:0] upper_temp_limit_ch1_o,
   input wire logic [11:0] upper_temp_limit_ch2_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   a_take_busy: assert property (
      conv_valid_i && conv_ready_o |=> !conv_ready_o) else $error("busy");
   a_result_lat: assert property (
      conv_valid_i && conv_ready_o |=> !result_valid_o ##[1:2] result_valid_o)
      else $error("result latency");
   a_first_fetch: assert property (
      conv_valid_i && conv_ready_o |-> mem_rd_o) else $error("no fetch");
   a_result_pulse: assert property (
      result_valid_o |=> !result_valid_o) else $error("result pulse");
   a_read_answer: assert property (
      cmd_valid_i && cmd_i[7] |=> cmd_rvalid_o) else $error("no read data");
   a_write_ch1: assert property (
      cmd_valid_i && cmd_i == 8'h20
      |=> upper_temp_limit_ch1_o == 12'($past(cmd_wdata_i))) else $error("w1");
   a_write_ch2: assert property (
      cmd_valid_i && cmd_i == 8'h28
      |=> upper_temp_limit_ch2_o == 12'($past(cmd_wdata_i))) else $error("w2");
   a_read_sext: assert property (
      cmd_valid_i && cmd_i == 8'hA0 |=> cmd_rdata_o
      == 16'($signed($past(upper_temp_limit_ch1_o)))) else $error("read");
   a_nv_load: assert property (
      nv_load_i && nv_sel_i && !cmd_valid_i
      |=> upper_temp_limit_ch2_o == 12'($past(nv_data_i))) else $error("nv");
endmodule // lai_checker
bind lai_top lai_checker u_lai_checker (.*);
`default_nettype wire

// [lai_nv_store.sv]
// nonvolatile store model with one cycle read latency
`timescale 1ns/1ps
`default_nettype none
module lai_nv_store (
   input  wire logic        clk_i,
   input  wire logic        rd_i,
   input  wire logic [7:0]  addr_i,
   output logic      [15:0] data_o
);
   // idle cycles invert the word so a stale read never passes
   always_ff @(posedge clk_i) begin
      data_o <= rd_i ? 16'h1000 + 16'(addr_i) * 16'h0025 : ~data_o;
   end
endmodule // lai_nv_store
`default_nettype wire

// [lai_top_tb_top.sv]
// self-checking bench for the interpolator top
`timescale 1ns/1ps
`default_nettype none
module lai_top_tb_top;
   logic        clk_i = 1'b0, sys_rst_i = 1'b1, conv_valid_i = 1'b0;
   logic        cmd_valid_i = 1'b0, nv_load_i = 1'b0, nv_sel_i = 1'b0;
   logic        conv_ready_o, result_valid_o, cfg_error_o, mem_rd_o;
   logic        cmd_rvalid_o;
   logic [7:0]  cmd_i = '0, mem_addr_o;
   logic [11:0] sample_i = '0, upper_temp_limit_ch1_o;
   logic [11:0] upper_temp_limit_ch2_o;
   logic [15:0] lut_cfg_i = '0, cmd_wdata_i = '0, nv_data_i = '0;
   logic [15:0] mem_data_i, result_o, cmd_rdata_o;
   logic [16:0] conv_q[$], reg_q[$], e;
   int          bad_count = 0, checks = 0;
   always #2.5 clk_i = ~clk_i;
   lai_top u_lai_top (.*);
   lai_nv_store u_lai_nv_store (.clk_i(clk_i), .rd_i(mem_rd_o),
      .addr_i(mem_addr_o), .data_o(mem_data_i));
   task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("bad_count=%0d checks=%0d", bad_count, checks);
      if (bad_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   function automatic logic [16:0] ref_conv(logic [11:0] s, logic [15:0] c);
      int d, p, last, f, a, w1, w2;
      d = int'(c[9:8]);
      p = int'(s >> (7 - c[7:6] - c[9:8]));
      p += int'($signed(c[15:10])) * (1 << d)
         * (c[7:6] == 2'd3 ? 4 : c[7:6] == 2'd2 ? 2 : 1);
      last = (int'(c[5:3]) * 32 - 1) << d;
      p = p < 0 ? 0 : p > last ? last : p;
      a = (int'(c[2:0]) * 32 + (p >> d)) % 256;
      f = (p % (1 << d)) << (3 - d);
      w1 = 4096 + a * 37;
      w2 = 4096 + ((a + 1) % 256) * 37;
      w1 += (f * (w2 - w1)) >>> 3;
      return {c[5:3] == 3'd0 || c[5:3] == 3'd7 || c[2:1] == 2'd0, w1[15:0]};
   endfunction
   task automatic conv(input logic [11:0] s, input logic [15:0] c);
      int n;
      n = 0;
      while (!conv_ready_o && n < 20) begin
         @(negedge clk_i);
         n++;
      end
      conv_q.push_back(ref_conv(s, c));
      conv_valid_i = 1'b1;
      sample_i = s;
      lut_cfg_i = c;
      @(negedge clk_i);
      conv_valid_i = 1'b0;
   endtask
   // load data is the inverse of write data so a wrong winner shows
   task automatic bus(input logic cv, nl, ns, input logic [7:0] op,
                      input logic [15:0] d, input logic [15:0] exp);
      if (cv && op[7])
         reg_q.push_back({1'b0, exp});
      cmd_valid_i = cv;
      cmd_i = op;
      cmd_wdata_i = d;
      nv_load_i = nl;
      nv_sel_i = ns;
      nv_data_i = ~d;
      @(negedge clk_i);
      cmd_valid_i = 1'b0;
      nv_load_i = 1'b0;
      @(negedge clk_i);
   endtask
   always @(posedge clk_i) begin
      if (result_valid_o) begin
         e = conv_q.pop_front();
         chk({cfg_error_o, e[16] ? e[15:0] : result_o}, e);
      end
      if (cmd_rvalid_o)
         chk({1'b0, cmd_rdata_o}, reg_q.pop_front());
   end
   initial begin
      repeat (4000) @(posedge clk_i);
      bad_count++;
      test_done();
   end
   initial begin
      void'($urandom(20));
      repeat (8) @(negedge clk_i);
      sys_rst_i = 1'b0;
      chk(17'(upper_temp_limit_ch1_o), 17'h7FF);
      bus(1'b1, 1'b0, 1'b0, 8'hA0, 16'h0555, 16'h07FF);
      bus(1'b1, 1'b0, 1'b0, 8'h20, 16'hF805, 16'h0);
      bus(1'b1, 1'b0, 1'b0, 8'hA0, 16'h0, 16'hF805);
      bus(1'b1, 1'b0, 1'b0, 8'hA2, 16'h0, 16'h0);
      bus(1'b1, 1'b0, 1'b0, 8'h28, 16'h0123, 16'h0);
      bus(1'b0, 1'b1, 1'b1, 8'h00, 16'h0C5F, 16'h0);
      bus(1'b1, 1'b0, 1'b0, 8'hA8, 16'h0, 16'h03A0);
      bus(1'b1, 1'b1, 1'b0, 8'h20, 16'h0011, 16'h0);
      chk(17'(upper_temp_limit_ch1_o), 17'h011);
      conv(12'h495, 16'h200A);
      conv(12'hE6A, 16'hA2A4);
      conv(12'h000, 16'h800B);
      conv(12'hFFF, 16'h00CF);
      conv(12'h3C1, 16'h0030);
      // an unused table must be flagged so the host keeps compensation off
      conv(12'h123, 16'h0002);
      conv(12'h7FF, 16'h003A);
      for (int i = 0; i < 64; i++) begin
         conv(12'($urandom), {6'($urandom), 2'(i), 2'(i >> 2),
              3'(1 + $urandom % 6), 3'(2 + $urandom % 6)});
      end
      repeat (10) @(negedge clk_i);
      chk(17'(conv_q.size()), 17'h0);
      test_done();
   end
endmodule // lai_top_tb_top
`default_nettype wire
